/* File: core/cts_pkg.sv */
/*
 * Constants for the charger and thermistor status register bank: register
 * offsets, field positions, status codes and pin vector layout.
 * Assumes the serial control port front end presents byte-wide register
 * accesses on sys_clk, and that the thermistor comparators and the charger
 * input detectors are asynchronous analog levels.
 */
// Overview of operation
// - Offset 0x00 is a read-only byte holding the silicon revision; writes do nothing.
// - Status bits 5:3 report the thermistor zone: 000 cold, 001 cool, 010 room, 011 warm, 100 hot.
// - The thermistor status reads 101 when the thermistor voltage is above the disconnect threshold.
// - It reads 110 when the charger input is valid with charger enable 00, or not valid with both enables 00.
// - It reads 111 when the charger input is not valid, charger enable is not 00 and harvester enable is 00.
// - Status bits 2:0 report the charger phase: 000 off, 010 precharge, 011 constant current.
// - The phase reads 100 in constant voltage, 101 in maintain charge and 110 after the maintain timer.
// - The phase reads 001 when suspended for temperature and 111 on a charger fault.
// - The charger input valid flag is 1 only when the input is present and within its valid range.
package cts_pkg;

	// Register offsets
	localparam logic [7:0] CTS_OFS_REVISION   = 8'h00;
	localparam logic [7:0] CTS_OFS_STATUS     = 8'h01;
	localparam logic [7:0] CTS_OFS_OTP_ADDR   = 8'h88;
	localparam logic [7:0] CTS_OFS_OTP_DATA   = 8'h89;

	// Revision value is arbitrary, chosen for this build
	localparam logic [7:0] CTS_SILICON_REVISION = 8'h5a;

	// Reset values and the value read back from unmapped offsets
	localparam logic [7:0] CTS_OTP_ADDR_RESET = 8'h00;
	localparam logic [7:0] CTS_READ_RESET     = 8'h00;
	localparam logic [7:0] CTS_UNMAPPED_READ  = 8'h00;

	// Status register field positions
	localparam int CTS_THM_LSB   = 3;
	localparam int CTS_THM_MSB   = 5;
	localparam int CTS_PHASE_LSB = 0;
	localparam int CTS_PHASE_MSB = 2;

	// Thermistor status codes
	localparam logic [2:0] CTS_THM_COLD     = 3'h0;
	localparam logic [2:0] CTS_THM_COOL     = 3'h1;
	localparam logic [2:0] CTS_THM_ROOM     = 3'h2;
	localparam logic [2:0] CTS_THM_WARM     = 3'h3;
	localparam logic [2:0] CTS_THM_HOT      = 3'h4;
	localparam logic [2:0] CTS_THM_NONE     = 3'h5;
	localparam logic [2:0] CTS_THM_OFF_BOTH = 3'h6;
	localparam logic [2:0] CTS_THM_OFF_HRV  = 3'h7;

	// Charger phase codes
	localparam logic [2:0] CTS_PH_OFF      = 3'h0;
	localparam logic [2:0] CTS_PH_SUSPEND  = 3'h1;
	localparam logic [2:0] CTS_PH_PRE      = 3'h2;
	localparam logic [2:0] CTS_PH_CC       = 3'h3;
	localparam logic [2:0] CTS_PH_CV       = 3'h4;
	localparam logic [2:0] CTS_PH_MAINTAIN = 3'h5;
	localparam logic [2:0] CTS_PH_DONE     = 3'h6;
	localparam logic [2:0] CTS_PH_FAULT    = 3'h7;

	// Thermistor enable value meaning monitoring off
	localparam logic [1:0] CTS_THM_EN_OFF = 2'h0;

	// Asynchronous pin vector layout
	localparam int CTS_PIN_GT_DIS   = 0;
	localparam int CTS_PIN_GT_COLD  = 1;
	localparam int CTS_PIN_GT_COOL  = 2;
	localparam int CTS_PIN_GT_WARM  = 3;
	localparam int CTS_PIN_GT_HOT   = 4;
	localparam int CTS_PIN_PRESENT  = 5;
	localparam int CTS_PIN_IN_RANGE = 6;
	localparam int CTS_PIN_COUNT    = 7;

endpackage

/* File: core/cts_thermistor_encoder.sv */
/*
 * Thermistor status encoder: turns synchronised comparator levels, the
 * charger input valid flag and the two thermistor enables into the
 * three-bit thermistor status code.
 * Assumes all inputs are already on sys_clk; purely combinational.
 */
module cts_thermistor_encoder
	import cts_pkg::*;
(
	input  wire logic       gtDis,
	input  wire logic       gtCold,
	input  wire logic       gtCool,
	input  wire logic       gtWarm,
	input  wire logic       gtHot,
	input  wire logic       chargerInputValid,
	input  wire logic [1:0] chargerThermistorEnable,
	input  wire logic [1:0] harvesterThermistorEnable,
	output logic      [2:0] thermistorZoneStatus
);

	logic chgOff;
	logic hrvOff;

	assign chgOff = (chargerThermistorEnable == CTS_THM_EN_OFF);
	assign hrvOff = (harvesterThermistorEnable == CTS_THM_EN_OFF);

	// Disabled monitoring wins: the comparators are unpowered then
	always_comb begin
		if ((chargerInputValid && chgOff) ||
				(!chargerInputValid && chgOff && hrvOff)) begin
			thermistorZoneStatus = CTS_THM_OFF_BOTH;
		end else if (!chargerInputValid && hrvOff) begin
			thermistorZoneStatus = CTS_THM_OFF_HRV;
		end else if (gtDis) begin
			thermistorZoneStatus = CTS_THM_NONE;
		end else if (gtCold) begin
			thermistorZoneStatus = CTS_THM_COLD;
		end else if (gtCool) begin
			thermistorZoneStatus = CTS_THM_COOL;
		end else if (gtWarm) begin
			thermistorZoneStatus = CTS_THM_ROOM;
		end else if (gtHot) begin
			thermistorZoneStatus = CTS_THM_WARM;
		end else begin
			thermistorZoneStatus = CTS_THM_HOT;
		end
	end

endmodule

/* File: core/cts_regs.sv */
/*
 * Charger and thermistor status register bank: revision byte, status byte
 * with thermistor zone and charger phase, and OTP readback address/data.
 * Assumes the serial control port decoder issues one-cycle register read
 * and write strobes on sys_clk, that the charger state machine and OTP
 * array sit on sys_clk, and that analog levels arrive asynchronously.
 */
module cts_regs
	import cts_pkg::*;
(
	input  wire logic       sys_clk,
	input  wire logic       rst,
	input  wire logic [7:0] regAddr,
	input  wire logic       regWrite,
	input  wire logic       regRead,
	input  wire logic [7:0] regWriteData,
	output logic      [7:0] regReadData,
	output logic            regReadValid,
	input  wire logic       thermistorAboveDisconnect,
	input  wire logic       thermistorAboveCold,
	input  wire logic       thermistorAboveCool,
	input  wire logic       thermistorAboveWarm,
	input  wire logic       thermistorAboveHot,
	input  wire logic       chargerInputPresent,
	input  wire logic       chargerInputInRange,
	input  wire logic [1:0] chargerThermistorEnable,
	input  wire logic [1:0] harvesterThermistorEnable,
	input  wire logic       chgFault,
	input  wire logic       chgTempSuspend,
	input  wire logic       chgTimerDone,
	input  wire logic       chgMaintain,
	input  wire logic       chgConstVoltage,
	input  wire logic       chgConstCurrent,
	input  wire logic       chgPrecharge,
	input  wire logic [7:0] otpByteValue,
	output logic      [7:0] otpByteAddress,
	output logic            chargerInputValid,
	output logic      [2:0] thermistorZoneStatus,
	output logic      [2:0] chargerPhaseStatus
);

	typedef struct packed {
		logic [CTS_PIN_COUNT-1:0] pinMeta;
		logic [CTS_PIN_COUNT-1:0] pinSync;
		logic                     inputValid;
		logic [2:0]               thermStatus;
		logic [2:0]               phaseStatus;
		logic [7:0]               otpAddress;
		logic [7:0]               readData;
		logic                     readValid;
	} cts_state_type;

	cts_state_type cur;
	cts_state_type next_cur;
	logic [CTS_PIN_COUNT-1:0] pinRaw;
	logic [2:0]               zoneCode;
	logic [7:0]               statusByte;

	// Address match, shared by write and read decode
	function automatic logic hitReg(input logic [7:0] addr,
			input logic [7:0] offset);
		hitReg = (addr == offset);
	endfunction

	// Charger phase priority: a fault outranks everything it could mask
	function automatic logic [2:0] phaseCode(input logic [6:0] flags);
		logic [2:0] code;
		code = CTS_PH_OFF;
		if (flags[6]) begin
			code = CTS_PH_FAULT;
		end else if (flags[5]) begin
			code = CTS_PH_SUSPEND;
		end else if (flags[4]) begin
			code = CTS_PH_DONE;
		end else if (flags[3]) begin
			code = CTS_PH_MAINTAIN;
		end else if (flags[2]) begin
			code = CTS_PH_CV;
		end else if (flags[1]) begin
			code = CTS_PH_CC;
		end else if (flags[0]) begin
			code = CTS_PH_PRE;
		end
		phaseCode = code;
	endfunction

	// Gather the asynchronous analog levels into one vector
	always_comb begin
		pinRaw = '0;
		pinRaw[CTS_PIN_GT_DIS]   = thermistorAboveDisconnect;
		pinRaw[CTS_PIN_GT_COLD]  = thermistorAboveCold;
		pinRaw[CTS_PIN_GT_COOL]  = thermistorAboveCool;
		pinRaw[CTS_PIN_GT_WARM]  = thermistorAboveWarm;
		pinRaw[CTS_PIN_GT_HOT]   = thermistorAboveHot;
		pinRaw[CTS_PIN_PRESENT]  = chargerInputPresent;
		pinRaw[CTS_PIN_IN_RANGE] = chargerInputInRange;
	end

	// Zone decode sees only the second synchroniser stage
	cts_thermistor_encoder u_encoder (
		.gtDis                     (cur.pinSync[CTS_PIN_GT_DIS]),
		.gtCold                    (cur.pinSync[CTS_PIN_GT_COLD]),
		.gtCool                    (cur.pinSync[CTS_PIN_GT_COOL]),
		.gtWarm                    (cur.pinSync[CTS_PIN_GT_WARM]),
		.gtHot                     (cur.pinSync[CTS_PIN_GT_HOT]),
		.chargerInputValid         (cur.inputValid),
		.chargerThermistorEnable   (chargerThermistorEnable),
		.harvesterThermistorEnable (harvesterThermistorEnable),
		.thermistorZoneStatus      (zoneCode)
	);

	// Status byte as seen by software
	always_comb begin
		statusByte = '0;
		statusByte[CTS_THM_MSB:CTS_THM_LSB] = cur.thermStatus;
		statusByte[CTS_PHASE_MSB:CTS_PHASE_LSB] = cur.phaseStatus;
	end

	// Next-state logic for the whole bank
	always_comb begin
		next_cur = cur;
		next_cur.pinMeta = pinRaw;
		next_cur.pinSync = cur.pinMeta;
		next_cur.inputValid = cur.pinSync[CTS_PIN_PRESENT] &&
			cur.pinSync[CTS_PIN_IN_RANGE];
		next_cur.thermStatus = zoneCode;
		next_cur.phaseStatus = phaseCode({chgFault, chgTempSuspend,
			chgTimerDone, chgMaintain, chgConstVoltage, chgConstCurrent,
			chgPrecharge});
		if (regWrite && hitReg(regAddr, CTS_OFS_OTP_ADDR)) begin
			next_cur.otpAddress = regWriteData;
		end
		// Reads answer one cycle later; writes elsewhere are dropped
		next_cur.readValid = regRead;
		if (regRead) begin
			if (hitReg(regAddr, CTS_OFS_REVISION)) begin
				next_cur.readData = CTS_SILICON_REVISION;
			end else if (hitReg(regAddr, CTS_OFS_STATUS)) begin
				next_cur.readData = statusByte;
			end else if (hitReg(regAddr, CTS_OFS_OTP_ADDR)) begin
				next_cur.readData = cur.otpAddress;
			end else if (hitReg(regAddr, CTS_OFS_OTP_DATA)) begin
				next_cur.readData = otpByteValue;
			end else begin
				next_cur.readData = CTS_UNMAPPED_READ;
			end
		end
	end

	// State register
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			cur <= '{pinMeta: '0, pinSync: '0, inputValid: 1'b0,
				thermStatus: CTS_THM_COLD, phaseStatus: CTS_PH_OFF,
				otpAddress: CTS_OTP_ADDR_RESET,
				readData: CTS_READ_RESET, readValid: 1'b0};
		end else begin
			cur <= next_cur;
		end
	end

	// Outputs come straight from the state flops
	assign regReadData          = cur.readData;
	assign regReadValid         = cur.readValid;
	assign otpByteAddress       = cur.otpAddress;
	assign chargerInputValid    = cur.inputValid;
	assign thermistorZoneStatus = cur.thermStatus;
	assign chargerPhaseStatus   = cur.phaseStatus;

	property p_revision;
		@(posedge sys_clk) disable iff (rst)
		regRead && regAddr == CTS_OFS_REVISION |=>
			regReadValid && regReadData == CTS_SILICON_REVISION;
	endproperty
	a_revision: assert property (p_revision)
		else $error("revision read mismatch");

	property p_status_top;
		@(posedge sys_clk) disable iff (rst)
		regRead && regAddr == CTS_OFS_STATUS |=>
			regReadData[7:6] == 2'h0 &&
			regReadData[5:3] == $past(thermistorZoneStatus);
	endproperty
	a_status_top: assert property (p_status_top)
		else $error("status read wrong");

	property p_zone_warm;
		@(posedge sys_clk) disable iff (rst)
		cur.inputValid && chargerThermistorEnable != CTS_THM_EN_OFF &&
			!cur.pinSync[CTS_PIN_GT_DIS] && !cur.pinSync[CTS_PIN_GT_WARM] &&
			cur.pinSync[CTS_PIN_GT_HOT] && !cur.pinSync[CTS_PIN_GT_COOL] &&
			!cur.pinSync[CTS_PIN_GT_COLD] |=>
			thermistorZoneStatus == CTS_THM_WARM;
	endproperty
	a_zone_warm: assert property (p_zone_warm)
		else $error("warm zone not reported");

	property p_no_thermistor;
		@(posedge sys_clk) disable iff (rst)
		cur.inputValid && chargerThermistorEnable != CTS_THM_EN_OFF &&
			cur.pinSync[CTS_PIN_GT_DIS] |=>
			thermistorZoneStatus == CTS_THM_NONE;
	endproperty
	a_no_thermistor: assert property (p_no_thermistor)
		else $error("missing thermistor not reported");

	property p_off_both;
		@(posedge sys_clk) disable iff (rst)
		chargerThermistorEnable == CTS_THM_EN_OFF &&
			(cur.inputValid ||
			harvesterThermistorEnable == CTS_THM_EN_OFF) |=>
			thermistorZoneStatus == CTS_THM_OFF_BOTH;
	endproperty
	a_off_both: assert property (p_off_both)
		else $error("disabled code 110 not reported");

	property p_off_hrv;
		@(posedge sys_clk) disable iff (rst)
		!cur.inputValid && chargerThermistorEnable != CTS_THM_EN_OFF &&
			harvesterThermistorEnable == CTS_THM_EN_OFF |=>
			thermistorZoneStatus == CTS_THM_OFF_HRV;
	endproperty
	a_off_hrv: assert property (p_off_hrv)
		else $error("disabled code 111 not reported");

	property p_precharge;
		@(posedge sys_clk) disable iff (rst)
		chgPrecharge && !chgConstCurrent && !chgConstVoltage &&
			!chgMaintain && !chgTimerDone && !chgTempSuspend &&
			!chgFault |=> chargerPhaseStatus == CTS_PH_PRE;
	endproperty
	a_precharge: assert property (p_precharge)
		else $error("precharge phase wrong");

	property p_const_voltage;
		@(posedge sys_clk) disable iff (rst)
		chgConstVoltage && !chgMaintain && !chgTimerDone &&
			!chgTempSuspend && !chgFault |=>
			chargerPhaseStatus == CTS_PH_CV;
	endproperty
	a_const_voltage: assert property (p_const_voltage)
		else $error("constant voltage phase wrong");

	property p_fault;
		@(posedge sys_clk) disable iff (rst)
		chgFault |=> chargerPhaseStatus == CTS_PH_FAULT;
	endproperty
	a_fault: assert property (p_fault)
		else $error("fault phase not reported");

	property p_input_invalid;
		@(posedge sys_clk) disable iff (rst)
		(chargerInputPresent && !chargerInputInRange)[*4] |->
			!chargerInputValid;
	endproperty
	a_input_invalid: assert property (p_input_invalid)
		else $error("charger input valid while out of range");

	property p_otp_readback;
		@(posedge sys_clk) disable iff (rst)
		regWrite && regAddr == CTS_OFS_OTP_ADDR ##1
			regRead && regAddr == CTS_OFS_OTP_DATA && !regWrite |=>
			otpByteAddress == $past(regWriteData, 2) &&
			regReadData == $past(otpByteValue);
	endproperty
	a_otp_readback: assert property (p_otp_readback)
		else $error("OTP readback mismatch");

	property p_const_current;
		@(posedge sys_clk) disable iff (rst)
		chgConstCurrent && !chgConstVoltage && !chgMaintain &&
			!chgTimerDone && !chgTempSuspend && !chgFault |=>
			chargerPhaseStatus == CTS_PH_CC;
	endproperty
	a_const_current: assert property (p_const_current)
		else $error("constant current phase wrong");

	property p_timer_done;
		@(posedge sys_clk) disable iff (rst)
		chgTimerDone && !chgTempSuspend && !chgFault |=>
			chargerPhaseStatus == CTS_PH_DONE;
	endproperty
	a_timer_done: assert property (p_timer_done)
		else $error("timer done phase wrong");

	property p_temp_suspend;
		@(posedge sys_clk) disable iff (rst)
		chgTempSuspend && !chgFault |=>
			chargerPhaseStatus == CTS_PH_SUSPEND;
	endproperty
	a_temp_suspend: assert property (p_temp_suspend)
		else $error("suspend phase wrong");

	// address only moves on its own write, so OTP reads stay put
	property p_addr_hold;
		@(posedge sys_clk) disable iff (rst)
		!(regWrite && regAddr == CTS_OFS_OTP_ADDR) |=>
			$stable(otpByteAddress);
	endproperty
	a_addr_hold: assert property (p_addr_hold)
		else $error("OTP address changed without a write");

endmodule

/* File: test/tb.sv */
/*
 * Self-checking bench for the charger and thermistor status register bank.
 * Assumes the strobe register port and level inputs of cts_regs; all
 * inputs are driven at the falling edge of a 10 MHz sys_clk.
 */
module tb
	import cts_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;

	logic       sys_clk;
	logic       rst;
	logic [7:0] regAddr;
	logic       regWrite;
	logic       regRead;
	logic [7:0] regWriteData;
	logic [7:0] regReadData;
	logic       regReadValid;
	logic [4:0] cmp;
	logic       present;
	logic       inRange;
	logic [1:0] chgEn;
	logic [1:0] hrvEn;
	logic [6:0] chgFlags;
	logic [7:0] otpByteValue;
	logic [7:0] otpByteAddress;
	logic       chargerInputValid;
	logic [2:0] thermistorZoneStatus;
	logic [2:0] chargerPhaseStatus;
	int         n_fail;
	int         compares;

	cts_regs DUT (
		.sys_clk(sys_clk), .rst(rst), .regAddr(regAddr),
		.regWrite(regWrite), .regRead(regRead),
		.regWriteData(regWriteData), .regReadData(regReadData),
		.regReadValid(regReadValid),
		.thermistorAboveDisconnect(cmp[4]), .thermistorAboveCold(cmp[3]),
		.thermistorAboveCool(cmp[2]), .thermistorAboveWarm(cmp[1]),
		.thermistorAboveHot(cmp[0]), .chargerInputPresent(present),
		.chargerInputInRange(inRange), .chargerThermistorEnable(chgEn),
		.harvesterThermistorEnable(hrvEn), .chgFault(chgFlags[6]),
		.chgTempSuspend(chgFlags[5]), .chgTimerDone(chgFlags[4]),
		.chgMaintain(chgFlags[3]), .chgConstVoltage(chgFlags[2]),
		.chgConstCurrent(chgFlags[1]), .chgPrecharge(chgFlags[0]),
		.otpByteValue(otpByteValue), .otpByteAddress(otpByteAddress),
		.chargerInputValid(chargerInputValid),
		.thermistorZoneStatus(thermistorZoneStatus),
		.chargerPhaseStatus(chargerPhaseStatus)
	);

	// Free-running system clock
	initial begin
		sys_clk = 1'b0;
		forever #50 sys_clk = ~sys_clk;
	end

	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		compares++;
		if (got !== exp) begin
			n_fail++;
			$display("[ERR] %0t ns: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic tally_and_finish;
		$display("compares=%0d n_fail=%0d", compares, n_fail);
		if (n_fail == 0 && compares > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	task automatic do_reset;
		rst = 1'b1;
		repeat (4) @(negedge sys_clk);
		rst = 1'b0;
	endtask

	// Strobe held one cycle; answer awaited under a bound
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		int k;
		@(negedge sys_clk);
		regAddr = a;
		regRead = 1'b1;
		@(negedge sys_clk);
		regRead = 1'b0;
		for (k = 0; k < 3 && regReadValid !== 1'b1; k++)
			@(negedge sys_clk);
		if (regReadValid !== 1'b1) begin
			n_fail++;
			$display("[ERR] %0t ns: read answer missing", $time);
			tally_and_finish();
		end
		d = regReadData;
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] v);
		@(negedge sys_clk);
		regAddr = a;
		regWriteData = v;
		regWrite = 1'b1;
		@(negedge sys_clk);
		regWrite = 1'b0;
	endtask

	// Revision byte and status spare bits, writes ignored
	task automatic t_regs;
		logic [7:0] d;
		rd(CTS_OFS_REVISION, d);
		chk(d, CTS_SILICON_REVISION);
		wr(CTS_OFS_REVISION, 8'hff);
		rd(CTS_OFS_REVISION, d);
		chk(d, CTS_SILICON_REVISION);
		wr(CTS_OFS_STATUS, 8'hff);
		rd(CTS_OFS_STATUS, d);
		chk(d, {2'h0, CTS_THM_OFF_BOTH, CTS_PH_OFF});
		$display("test regs done");
	endtask

	// One charger flag at a time, then all at once for priority
	task automatic t_phase;
		logic [2:0] exp [8];
		logic [7:0] d;
		logic [2:0] want;
		exp = '{CTS_PH_OFF, CTS_PH_PRE, CTS_PH_CC, CTS_PH_CV,
			CTS_PH_MAINTAIN, CTS_PH_DONE, CTS_PH_SUSPEND, CTS_PH_FAULT};
		for (int i = 0; i < 9; i++) begin
			chgFlags = (i == 0) ? 7'h00 : (i == 8) ? 7'h7f : 7'h01 << (i - 1);
			// All flags at once must still read as a fault
			want = exp[(i == 8) ? 7 : i];
			rd(CTS_OFS_STATUS, d);
			chk({5'h0, chargerPhaseStatus}, {5'h0, want});
			chk(d, {2'h0, CTS_THM_OFF_BOTH, want});
		end
		chgFlags = 7'h00;
		$display("test phase done");
	endtask

	// Apply pins, let the synchronisers settle, then judge
	task automatic tz(input logic [4:0] c, input logic p, input logic r,
		input logic [1:0] ce, input logic [1:0] he, input logic v,
		input logic [2:0] z);
		logic [7:0] d;
		cmp = c;
		present = p;
		inRange = r;
		chgEn = ce;
		hrvEn = he;
		repeat (6) @(negedge sys_clk);
		chk({7'h0, chargerInputValid}, {7'h0, v});
		chk({5'h0, thermistorZoneStatus}, {5'h0, z});
		rd(CTS_OFS_STATUS, d);
		chk(d, {2'h0, z, CTS_PH_OFF});
	endtask

	task automatic t_zone;
		tz(5'h0f, 1'b1, 1'b1, 2'h1, 2'h0, 1'b1, CTS_THM_COLD);
		tz(5'h07, 1'b1, 1'b1, 2'h1, 2'h0, 1'b1, CTS_THM_COOL);
		tz(5'h03, 1'b1, 1'b1, 2'h1, 2'h0, 1'b1, CTS_THM_ROOM);
		tz(5'h01, 1'b1, 1'b1, 2'h1, 2'h0, 1'b1, CTS_THM_WARM);
		tz(5'h00, 1'b1, 1'b1, 2'h3, 2'h0, 1'b1, CTS_THM_HOT);
		tz(5'h1f, 1'b1, 1'b1, 2'h2, 2'h0, 1'b1, CTS_THM_NONE);
		tz(5'h1f, 1'b1, 1'b1, 2'h0, 2'h2, 1'b1, CTS_THM_OFF_BOTH);
		tz(5'h00, 1'b0, 1'b0, 2'h0, 2'h0, 1'b0, CTS_THM_OFF_BOTH);
		tz(5'h00, 1'b0, 1'b0, 2'h2, 2'h0, 1'b0, CTS_THM_OFF_HRV);
		tz(5'h00, 1'b1, 1'b0, 2'h1, 2'h0, 1'b0, CTS_THM_OFF_HRV);
		tz(5'h00, 1'b0, 1'b1, 2'h3, 2'h0, 1'b0, CTS_THM_OFF_HRV);
		tz(5'h03, 1'b0, 1'b0, 2'h1, 2'h3, 1'b0, CTS_THM_ROOM);
		tz(5'h00, 1'b0, 1'b0, 2'h0, 2'h0, 1'b0, CTS_THM_OFF_BOTH);
		$display("test zone done");
	endtask

	// OTP readback address and data, plus refused and unmapped places
	task automatic t_otp;
		logic [7:0] d;
		otpByteValue = 8'h3c;
		wr(CTS_OFS_OTP_ADDR, 8'ha5);
		chk(otpByteAddress, 8'ha5);
		rd(CTS_OFS_OTP_DATA, d);
		chk(d, 8'h3c);
		rd(CTS_OFS_OTP_ADDR, d);
		chk(d, 8'ha5);
		wr(CTS_OFS_OTP_DATA, 8'h00);
		chk(otpByteAddress, 8'ha5);
		otpByteValue = 8'hc3;
		wr(CTS_OFS_OTP_ADDR, 8'hff);
		rd(CTS_OFS_OTP_DATA, d);
		chk(d, 8'hc3);
		chk(otpByteAddress, 8'hff);
		// Write then read on the next edge: the read must answer one cycle later and the address must already be the new one
		@(negedge sys_clk);
		regAddr = CTS_OFS_OTP_ADDR;
		regWriteData = 8'h5e;
		regWrite = 1'b1;
		@(negedge sys_clk);
		regWrite = 1'b0;
		regAddr = CTS_OFS_OTP_DATA;
		regRead = 1'b1;
		@(negedge sys_clk);
		regRead = 1'b0;
		chk({7'h0, regReadValid}, 8'h01);
		chk(regReadData, 8'hc3);
		chk(otpByteAddress, 8'h5e);
		@(negedge sys_clk);
		chk({7'h0, regReadValid}, 8'h00);
		wr(8'h02, 8'h77);
		rd(8'h02, d);
		chk(d, CTS_UNMAPPED_READ);
		$display("test otp done");
	endtask

	// Reset in mid-run restores the address register
	task automatic t_rerun;
		logic [7:0] d;
		do_reset();
		chk(otpByteAddress, CTS_OTP_ADDR_RESET);
		chk({7'h0, chargerInputValid}, 8'h00);
		chk({5'h0, chargerPhaseStatus}, {5'h0, CTS_PH_OFF});
		// First read right after a mid-run reset must still answer
		rd(CTS_OFS_REVISION, d);
		chk(d, CTS_SILICON_REVISION);
		$display("test reset done");
	endtask

	// Main sequence
	initial begin
		n_fail = 0;
		compares = 0;
		regAddr = 8'h00;
		regWrite = 1'b0;
		regRead = 1'b0;
		regWriteData = 8'h00;
		cmp = 5'h00;
		present = 1'b0;
		inRange = 1'b0;
		chgEn = 2'h0;
		hrvEn = 2'h0;
		chgFlags = 7'h00;
		otpByteValue = 8'h00;
		do_reset();
		repeat (6) @(negedge sys_clk);
		t_regs();
		t_phase();
		t_zone();
		t_otp();
		t_rerun();
		tally_and_finish();
	end
endmodule
